// *** src/pmsf_top.v ***
// Contract
// R1: Healthy flag drops on watchdog error
// R2: Host ready sets online state
// R3: Host ready low leaves online
// R4: No online for 500 ms after reset
// R5: Upper overtravel when position above limit
// R6: Lower overtravel when position below limit
// R7: Overtravel evaluated only while online
// R8: Positioning continues during overtravel
// R9: Overtravel clears after return and reset
// R10: Sensor fault flag on detection failure
// R11: Sensor fault clears on reset once removed
// R12: Excess correction flag on large preset
// R13: Preset value applied despite excess flag
// R14: Excess correction clears on error reset
// R15: Jump flag on large 20 ms change
// R16: Jump flag clears on error reset
// R17: Summary error on any axis fault
// R18: Summary clears on reset after causes
// R19: Eight channel outputs per axis
// R20: Error reset acts on rising edge
// R21: Persisting cause keeps flag set
// R22: Independent flags, shared reset for both
`timescale 1ns/1ns
`default_nettype none
`include "pmsf_defs.vh"

module pmsf_top #(
    parameter [31:0] HOLD_CYCLES =
        `PMSF_ONLINE_HOLD_MS * (`PMSF_CLK_KHZ),
    parameter [31:0] WINDOW_CYCLES =
        `PMSF_JUMP_WINDOW_MS * (`PMSF_CLK_KHZ)
) (
    input wire ref_clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire hostReady,
    input wire faultClear,
    input wire watchdogError,
    input wire sensorOkAxisOne,
    input wire sensorOkAxisTwo,
    input wire [31:0] measuredAxisOne,
    input wire [31:0] measuredAxisTwo,
    input wire presetAxisOne,
    input wire presetAxisTwo,
    input wire [31:0] presetValueAxisOne,
    input wire [31:0] presetValueAxisTwo,
    input wire [7:0] channelSourceAxisOne,
    input wire [7:0] channelSourceAxisTwo,
    output reg moduleHealthy,
    output reg onlineFlag,
    output reg upperOvertravelAxisOne,
    output reg upperOvertravelAxisTwo,
    output reg lowerOvertravelAxisOne,
    output reg lowerOvertravelAxisTwo,
    output reg sensorFaultAxisOne,
    output reg sensorFaultAxisTwo,
    output reg anyFaultAxisOne,
    output reg anyFaultAxisTwo,
    output reg correctionExcessAxisOne,
    output reg correctionExcessAxisTwo,
    output reg positionJumpAxisOne,
    output reg positionJumpAxisTwo,
    output reg [7:0] channelOutputsAxisOne,
    output reg [7:0] channelOutputsAxisTwo
);
    localparam [2:0] ST_HOLD = 3'h1;
    localparam [2:0] ST_OFFLINE = 3'h2;
    localparam [2:0] ST_ONLINE = 3'h4;

    reg [2:0] state;
    reg [31:0] holdCount;
    reg [31:0] windowCount;
    reg windowTick;
    reg clearPrev;
    reg clearPulse;
    reg watchdogSeen;
    reg [2:0] control;
    reg [31:0] limits [0:7];
    reg dataPhase;
    reg dataWrite;
    reg [11:0] dataAddr;
    reg [31:0] next_hrdata;
    wire [31:0] position [0:1];
    wire [1:0] upperOver;
    wire [1:0] lowerOver;
    wire [1:0] sensFault;
    wire [1:0] corrExc;
    wire [1:0] posJump;
    wire [1:0] anyFault;
    wire [1:0] sensorOk;
    wire [1:0] presetLoad;
    wire [31:0] presetValue [0:1];
    wire [31:0] measured [0:1];
    wire addrPhase;
    wire online;

    // Limit slot for an address, 3'h7 when not a limit register and also for PMSF_ADDR_JUMP2
    function [2:0] limitSlot;
        input [11:0] addr;
        begin
            if (addr == `PMSF_ADDR_UPPER1)
                limitSlot = 3'h0;
            else if (addr == `PMSF_ADDR_LOWER1)
                limitSlot = 3'h1;
            else if (addr == `PMSF_ADDR_UPPER2)
                limitSlot = 3'h2;
            else if (addr == `PMSF_ADDR_LOWER2)
                limitSlot = 3'h3;
            else if (addr == `PMSF_ADDR_CORR1)
                limitSlot = 3'h4;
            else if (addr == `PMSF_ADDR_CORR2)
                limitSlot = 3'h5;
            else if (addr == `PMSF_ADDR_JUMP1)
                limitSlot = 3'h6;
            else
                limitSlot = 3'h7;
        end
    endfunction

    // Only aligned whole-word transfers reach the registers
    function wordAccess;
        input [31:0] addr;
        input [2:0] size;
        begin
            wordAccess = (addr[1:0] == `PMSF_ADDR_ALIGN) &&
                (size == `PMSF_HSIZE_WORD);
        end
    endfunction

    assign online = (state == ST_ONLINE);
    assign sensorOk = {sensorOkAxisTwo, sensorOkAxisOne};
    assign presetLoad = {presetAxisTwo, presetAxisOne};
    assign presetValue[0] = presetValueAxisOne;
    assign presetValue[1] = presetValueAxisTwo;
    assign measured[0] = measuredAxisOne;
    assign measured[1] = measuredAxisTwo;
    assign addrPhase = hsel && hready && (htrans == `PMSF_HTRANS_NONSEQ);

    // Online state with post-reset hold-off
    always @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_HOLD;
            holdCount <= 32'h0;
        end else begin
            case (state)
                ST_HOLD: begin
                    // Host ready is ignored until the hold expires
                    if (holdCount >= HOLD_CYCLES - 32'h1)
                        state <= ST_OFFLINE; // R4
                    else
                        holdCount <= holdCount + 32'h1;
                end
                ST_OFFLINE: begin
                    if (hostReady)
                        state <= ST_ONLINE; // R2
                end
                ST_ONLINE: begin
                    if (!hostReady)
                        state <= ST_OFFLINE; // R3
                end
                default: state <= ST_HOLD;
            endcase
        end
    end

    // Shared edge detect; idle low, so no false edge after reset
    always @(posedge ref_clk) begin
        if (rst) begin
            clearPrev <= 1'b0;
            clearPulse <= 1'b0;
        end else begin
            clearPrev <= faultClear;
            clearPulse <= faultClear & !clearPrev; // R20 R22
        end
    end

    // The 20 ms position-change window
    always @(posedge ref_clk) begin
        if (rst) begin
            windowCount <= 32'h0;
            windowTick <= 1'b0;
        end else begin
            windowTick <= (windowCount >= WINDOW_CYCLES - 32'h1);
            if (windowCount >= WINDOW_CYCLES - 32'h1)
                windowCount <= 32'h0;
            else
                windowCount <= windowCount + 32'h1;
        end
    end

    // Watchdog fault is a hardware error; only reset clears it
    always @(posedge ref_clk) begin
        if (rst) begin
            watchdogSeen <= 1'b0;
        end else if (watchdogError | control[`PMSF_CTL_WDOG]) begin
            watchdogSeen <= 1'b1; // R1
        end
    end

    genvar ax;
    generate
        for (ax = 0; ax < 2; ax = ax + 1) begin : gAxis
            pmsf_axis uAxis (
                .refClk(ref_clk),
                .rst(rst),
                .online(online),
                .clearPulse(clearPulse),
                .windowTick(windowTick),
                .sensorOk(sensorOk[ax]),
                .presetLoad(presetLoad[ax]),
                .presetValue(presetValue[ax]),
                .measured(measured[ax]),
                .upperLimit(limits[2 * ax]),
                .lowerLimit(limits[2 * ax + 1]),
                .corrLimit(limits[4 + ax]),
                .jumpLimit(limits[6 + ax]),
                .moduleError(control[ax]),
                .position(position[ax]),
                .upperOver(upperOver[ax]),
                .lowerOver(lowerOver[ax]),
                .sensorFault(sensFault[ax]),
                .corrExcess(corrExc[ax]),
                .posJump(posJump[ax]),
                .anyFault(anyFault[ax])
            ); // R22
        end
    endgenerate

    // Registered flag outputs
    always @(posedge ref_clk) begin
        if (rst) begin
            moduleHealthy <= 1'b0;
            onlineFlag <= 1'b0;
            upperOvertravelAxisOne <= 1'b0;
            upperOvertravelAxisTwo <= 1'b0;
            lowerOvertravelAxisOne <= 1'b0;
            lowerOvertravelAxisTwo <= 1'b0;
            sensorFaultAxisOne <= 1'b0;
            sensorFaultAxisTwo <= 1'b0;
            anyFaultAxisOne <= 1'b0;
            anyFaultAxisTwo <= 1'b0;
            correctionExcessAxisOne <= 1'b0;
            correctionExcessAxisTwo <= 1'b0;
            positionJumpAxisOne <= 1'b0;
            positionJumpAxisTwo <= 1'b0;
            channelOutputsAxisOne <= 8'h0;
            channelOutputsAxisTwo <= 8'h0;
        end else begin
            moduleHealthy <= !watchdogSeen && !watchdogError; // R1
            onlineFlag <= online; // R2 R3
            upperOvertravelAxisOne <= upperOver[0];
            upperOvertravelAxisTwo <= upperOver[1];
            lowerOvertravelAxisOne <= lowerOver[0];
            lowerOvertravelAxisTwo <= lowerOver[1];
            sensorFaultAxisOne <= sensFault[0];
            sensorFaultAxisTwo <= sensFault[1];
            anyFaultAxisOne <= anyFault[0];
            anyFaultAxisTwo <= anyFault[1];
            correctionExcessAxisOne <= corrExc[0];
            correctionExcessAxisTwo <= corrExc[1];
            positionJumpAxisOne <= posJump[0];
            positionJumpAxisTwo <= posJump[1];
            // Channels drop while offline
            channelOutputsAxisOne <= online ? channelSourceAxisOne : 8'h0; // R19
            channelOutputsAxisTwo <= online ? channelSourceAxisTwo : 8'h0; // R19
        end
    end

    // AHB-Lite slave, zero wait states; read value taken at address phase
    always @* begin
        next_hrdata = 32'h0;
        if (haddr[11:0] == `PMSF_ADDR_STATUS)
            next_hrdata = {17'h0, channelOutputsAxisTwo[0], anyFault,
                posJump, corrExc, sensFault, lowerOver, upperOver,
                onlineFlag, moduleHealthy};
        else if (haddr[11:0] == `PMSF_ADDR_CONTROL)
            next_hrdata = {29'h0, control};
        else if (limitSlot(haddr[11:0]) != 3'h7)
            next_hrdata = limits[limitSlot(haddr[11:0])];
        else if (haddr[11:0] == `PMSF_ADDR_JUMP2)
            next_hrdata = limits[7];
        // Positions are read-only; writes to them are dropped
        else if (haddr[11:0] == `PMSF_ADDR_POS1)
            next_hrdata = position[0];
        else if (haddr[11:0] == `PMSF_ADDR_POS2)
            next_hrdata = position[1];
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr <= 12'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dataPhase <= addrPhase && wordAccess(haddr, hsize);
            dataWrite <= addrPhase && hwrite;
            dataAddr <= haddr[11:0];
            // Refused transfers still get a zero-wait OKAY
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            // Loaded here so it stands through the following data phase
            if (addrPhase && !hwrite && wordAccess(haddr, hsize))
                hrdata <= next_hrdata;
            else
                hrdata <= 32'h0;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            control <= 3'h0;
            limits[0] <= `PMSF_UPPER_RST;
            limits[1] <= `PMSF_LOWER_RST;
            limits[2] <= `PMSF_UPPER_RST;
            limits[3] <= `PMSF_LOWER_RST;
            limits[4] <= `PMSF_CORR_RST;
            limits[5] <= `PMSF_CORR_RST;
            limits[6] <= `PMSF_JUMP_RST;
            limits[7] <= `PMSF_JUMP_RST;
        end else if (dataPhase && dataWrite) begin
            if (dataAddr == `PMSF_ADDR_CONTROL)
                control <= hwdata[2:0];
            else if (limitSlot(dataAddr) != 3'h7)
                limits[limitSlot(dataAddr)] <= hwdata;
            else if (dataAddr == `PMSF_ADDR_JUMP2)
                limits[7] <= hwdata;
        end
    end
endmodule
`default_nettype wire

// *** src/pmsf_defs.vh ***
`ifndef PMSF_DEFS_VH
`define PMSF_DEFS_VH

// Bus register byte offsets
`define PMSF_ADDR_STATUS 12'h000
`define PMSF_ADDR_CONTROL 12'h004
`define PMSF_ADDR_UPPER1 12'h008
`define PMSF_ADDR_LOWER1 12'h00c
`define PMSF_ADDR_UPPER2 12'h010
`define PMSF_ADDR_LOWER2 12'h014
`define PMSF_ADDR_CORR1 12'h018
`define PMSF_ADDR_CORR2 12'h01c
`define PMSF_ADDR_JUMP1 12'h020
`define PMSF_ADDR_JUMP2 12'h024
`define PMSF_ADDR_POS1 12'h028
`define PMSF_ADDR_POS2 12'h02c
`define PMSF_ADDR_ALIGN 2'h0

// Reset values of the limit registers
`define PMSF_UPPER_RST 32'h7fffffff
`define PMSF_LOWER_RST 32'h80000000
`define PMSF_CORR_RST 32'h7fffffff
`define PMSF_JUMP_RST 32'h7fffffff

// AHB encodings
`define PMSF_HTRANS_NONSEQ 2'h2
`define PMSF_HSIZE_WORD 3'h2

// Timing: clock in kHz, times in ms
`define PMSF_CLK_KHZ 25000
`define PMSF_ONLINE_HOLD_MS 500
`define PMSF_JUMP_WINDOW_MS 20
`define PMSF_CLEAR_MAX_MS 12

// Control register bits
`define PMSF_CTL_MODERR1 0
`define PMSF_CTL_MODERR2 1
`define PMSF_CTL_WDOG 2

`endif

// *** src/pmsf_axis.v ***
`timescale 1ns/1ns
`default_nettype none
`include "pmsf_defs.vh"

module pmsf_axis (
    input wire refClk,
    input wire rst,
    input wire online,
    input wire clearPulse,
    input wire windowTick,
    input wire sensorOk,
    input wire presetLoad,
    input wire [31:0] presetValue,
    input wire [31:0] measured,
    input wire [31:0] upperLimit,
    input wire [31:0] lowerLimit,
    input wire [31:0] corrLimit,
    input wire [31:0] jumpLimit,
    input wire moduleError,
    output reg [31:0] position,
    output reg upperOver,
    output reg lowerOver,
    output reg sensorFault,
    output reg corrExcess,
    output reg posJump,
    output reg anyFault
);
    reg [31:0] offset;
    reg [31:0] windowStart;
    wire [31:0] scaled;
    wire [31:0] newOffset;
    wire upperNow;
    wire lowerNow;
    wire corrNow;
    wire jumpNow;
    wire causes;

    function [31:0] absDiff;
        input [31:0] a;
        input [31:0] b;
        begin
            absDiff = ($signed(a) > $signed(b)) ? a - b : b - a;
        end
    endfunction

    assign scaled = measured + offset;
    assign newOffset = presetValue - measured;
    assign upperNow = online && ($signed(scaled) > $signed(upperLimit));
    assign lowerNow = online && ($signed(scaled) < $signed(lowerLimit));
    assign corrNow = presetLoad && (absDiff(presetValue, scaled) > corrLimit);
    assign jumpNow = windowTick && (absDiff(scaled, windowStart) > jumpLimit);
    assign causes = upperNow | lowerNow | !sensorOk | moduleError;

    always @(posedge refClk) begin
        if (rst) begin
            offset <= 32'h0;
            windowStart <= 32'h0;
            position <= 32'h0;
            upperOver <= 1'b0;
            lowerOver <= 1'b0;
            sensorFault <= 1'b0;
            corrExcess <= 1'b0;
            posJump <= 1'b0;
            anyFault <= 1'b0;
        end else begin
            // Preset always applied, flagged or not
            if (presetLoad)
                offset <= newOffset; // R13
            position <= scaled; // R8
            if (windowTick)
                windowStart <= scaled;
            // Set terms win over the clear pulse
            upperOver <= upperNow | (upperOver & !clearPulse); // R5 R7 R9 R21
            lowerOver <= lowerNow | (lowerOver & !clearPulse); // R6 R7 R9 R21
            sensorFault <= !sensorOk | (sensorFault & !clearPulse); // R10 R11
            corrExcess <= corrNow | (corrExcess & !clearPulse); // R12 R14
            posJump <= jumpNow | (posJump & !clearPulse); // R15 R16
            // Old flags only hold the summary, so one clear drops it too
            anyFault <= causes | corrNow | jumpNow |
                ((upperOver | lowerOver | sensorFault | corrExcess |
                posJump | anyFault) & !clearPulse); // R17 R18
        end
    end
endmodule
`default_nettype wire

// *** sim/pmsf_top_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module pmsf_top_monitor #(
    parameter [31:0] HOLD_CYCLES = 32'h14
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hostReady,
    input wire logic faultClear,
    input wire logic watchdogError,
    input wire logic sensorOkAxisTwo,
    input wire logic [7:0] channelSourceAxisOne,
    input wire logic moduleHealthy,
    input wire logic onlineFlag,
    input wire logic upperOvertravelAxisOne,
    input wire logic lowerOvertravelAxisTwo,
    input wire logic sensorFaultAxisTwo,
    input wire logic anyFaultAxisOne,
    input wire logic correctionExcessAxisOne,
    input wire logic positionJumpAxisOne,
    input wire logic [7:0] channelOutputsAxisOne
);
    logic [31:0] upTime;

    // Saturates so a long run never wraps back into the hold-off span
    always @(posedge ref_clk) begin
        if (rst) begin
            upTime <= 32'h0;
        end else if (upTime != 32'hffffffff) begin
            upTime <= upTime + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    health_drop_a: assert property (
        watchdogError |-> ##[1:3] !moduleHealthy)
        else $error("healthy flag stayed high after watchdog error");
    online_rise_a: assert property (
        hostReady[*6] ##0 (upTime > HOLD_CYCLES + 32'h8) |-> onlineFlag)
        else $error("online flag missing with host ready");
    online_drop_a: assert property (
        !hostReady |-> ##[1:3] !onlineFlag)
        else $error("online flag stayed high without host ready");
    hold_off_a: assert property (
        onlineFlag |-> upTime >= HOLD_CYCLES)
        else $error("online flag raised during hold-off");
    offline_ot_a: assert property (
        $rose(upperOvertravelAxisOne) || $rose(lowerOvertravelAxisTwo)
        |-> $past(onlineFlag))
        else $error("overtravel raised while offline");
    sensor_hold_a: assert property (
        !sensorOkAxisTwo |-> ##2 sensorFaultAxisTwo)
        else $error("sensor fault flag low while sensor bad");
    summary_err_a: assert property (
        upperOvertravelAxisOne || correctionExcessAxisOne ||
        positionJumpAxisOne |-> ##[0:2] anyFaultAxisOne)
        else $error("summary flag missing for axis one");
    clear_edge_a: assert property (
        $fell(correctionExcessAxisOne)
        |-> $past(faultClear, 3) && !$past(faultClear, 4))
        else $error("correction flag fell without clear edge");
    chan_pass_a: assert property (
        $past(onlineFlag) && $past(hostReady) && $past(hostReady, 2)
        |-> channelOutputsAxisOne == $past(channelSourceAxisOne))
        else $error("channel outputs do not follow source");
endmodule

bind pmsf_top pmsf_top_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) mon (
    .ref_clk(ref_clk), .rst(rst), .hostReady(hostReady),
    .faultClear(faultClear), .watchdogError(watchdogError),
    .sensorOkAxisTwo(sensorOkAxisTwo),
    .channelSourceAxisOne(channelSourceAxisOne),
    .moduleHealthy(moduleHealthy), .onlineFlag(onlineFlag),
    .upperOvertravelAxisOne(upperOvertravelAxisOne),
    .lowerOvertravelAxisTwo(lowerOvertravelAxisTwo),
    .sensorFaultAxisTwo(sensorFaultAxisTwo),
    .anyFaultAxisOne(anyFaultAxisOne),
    .correctionExcessAxisOne(correctionExcessAxisOne),
    .positionJumpAxisOne(positionJumpAxisOne),
    .channelOutputsAxisOne(channelOutputsAxisOne));
`default_nettype wire

// *** sim/pmsf_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module pmsf_host (
    input wire logic ref_clk,
    output logic hostReady,
    output logic faultClear
);
    initial begin
        hostReady = 1'b0;
        faultClear = 1'b0;
    end

    task automatic setReady(input logic v);
        @(posedge ref_clk);
        hostReady <= v;
    endtask

    task automatic setClear(input logic v);
        @(posedge ref_clk);
        faultClear <= v;
    endtask

    // A slow sequence program holds the clear for several scans
    task automatic pulseClear(input int len);
        setClear(1'b1);
        repeat (len) @(posedge ref_clk);
        faultClear <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** sim/tb_pmsf_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pmsf_defs.vh"
module tb_pmsf_top;
    localparam [31:0] HOLD = 32'h14;
    localparam [31:0] WIN = 32'h10;
    logic ref_clk, rst, hsel, hwrite, wdog, pre1, pre2, ok1, ok2, rdPhase;
    logic [31:0] haddr, hwdata, m1, m2, pv1, pv2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] src1, src2;
    wire [31:0] hrdata;
    wire hreadyout, hresp, hostReady, faultClear;
    wire hready = hreadyout;
    wire [13:0] outs;
    int num_errors = 0;
    int compares = 0;
    logic [63:0] expQ[$];

    pmsf_top #(.HOLD_CYCLES(HOLD), .WINDOW_CYCLES(WIN)) uut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .hostReady(hostReady), .faultClear(faultClear),
        .watchdogError(wdog), .sensorOkAxisOne(ok1), .sensorOkAxisTwo(ok2),
        .measuredAxisOne(m1), .measuredAxisTwo(m2),
        .presetAxisOne(pre1), .presetAxisTwo(pre2),
        .presetValueAxisOne(pv1), .presetValueAxisTwo(pv2),
        .channelSourceAxisOne(src1), .channelSourceAxisTwo(src2),
        .moduleHealthy(outs[0]), .onlineFlag(outs[1]),
        .upperOvertravelAxisOne(outs[2]), .upperOvertravelAxisTwo(outs[3]),
        .lowerOvertravelAxisOne(outs[4]), .lowerOvertravelAxisTwo(outs[5]),
        .sensorFaultAxisOne(outs[6]), .sensorFaultAxisTwo(outs[7]),
        .correctionExcessAxisOne(outs[8]),
        .correctionExcessAxisTwo(outs[9]),
        .positionJumpAxisOne(outs[10]), .positionJumpAxisTwo(outs[11]),
        .anyFaultAxisOne(outs[12]), .anyFaultAxisTwo(outs[13]),
        .channelOutputsAxisOne(), .channelOutputsAxisTwo());
    pmsf_host host (.ref_clk(ref_clk), .hostReady(hostReady),
        .faultClear(faultClear));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, m);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= `PMSF_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        if (!wr) expQ.push_back({m, d & m});
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, e, 32'hffffffff);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask

    // Bit 14 mirrors a random channel source, so it is left out
    task automatic rs(input logic [31:0] e);
        @(negedge ref_clk);
        check("flag outputs", {18'h0, outs}, e & 32'h3fff);
        bus(1'b0, `PMSF_ADDR_STATUS, e, 32'hffffbfff);
    endtask

    always @(posedge ref_clk) begin
        src1 <= 8'($urandom);
        src2 <= 8'($urandom);
        if (rdPhase && hready === 1'b1) begin
            check("read data", hrdata & expQ[0][63:32], expQ[0][31:0]);
            check("response", {31'h0, hresp}, 32'h0);
            void'(expQ.pop_front());
        end
        if (hready === 1'b1) begin
            rdPhase <= hsel && htrans == `PMSF_HTRANS_NONSEQ && !hwrite;
        end
    end

    initial begin
        tick(3000);
        num_errors++;
        end_of_test();
    end

    initial begin
        {rst, ok1, ok2} = 3'h7;
        {hsel, hwrite, wdog, pre1, pre2, rdPhase} = 6'h0;
        {haddr, hwdata, m1, m2, pv1, pv2} = 192'h0;
        {htrans, src1, src2} = 18'h0;
        hsize = `PMSF_HSIZE_WORD;
        void'($urandom(53022));
        tick(2);
        rst <= 1'b0;
        host.setReady(1'b1);
        rd(`PMSF_ADDR_UPPER1, `PMSF_UPPER_RST);
        rd(`PMSF_ADDR_LOWER2, `PMSF_LOWER_RST);
        rd(`PMSF_ADDR_CORR1, `PMSF_CORR_RST);
        rd(`PMSF_ADDR_JUMP2, `PMSF_JUMP_RST);
        rs(32'h1);
        rd(`PMSF_ADDR_CONTROL, 32'h0);
        wr(12'h040, 32'h5a5a5a5a);
        rd(12'h040, 32'h0);
        tick(HOLD);
        rs(32'h3);
        wr(`PMSF_ADDR_UPPER1, 32'h64);
        wr(`PMSF_ADDR_LOWER2, 32'hffffff9c);
        m1 <= 32'h65 + ($urandom % 32'h100);
        m2 <= 32'hffffff9b - ($urandom % 32'h100);
        tick(4);
        rs(32'h3027);
        host.pulseClear(1);
        tick(4);
        rs(32'h3027);
        m1 <= 32'h0;
        m2 <= 32'h0;
        tick(4);
        rs(32'h3027);
        host.pulseClear(5);
        tick(4);
        rs(32'h3);
        host.setReady(1'b0);
        tick(2);
        m1 <= 32'h1000;
        tick(4);
        rs(32'h1);
        m1 <= 32'h0;
        host.setReady(1'b1);
        tick(6);
        rs(32'h3);
        {ok1, ok2} <= 2'h0;
        tick(4);
        host.setClear(1'b1);
        tick(4);
        rs(32'h30c3);
        {ok1, ok2} <= 2'h3;
        tick(4);
        rs(32'h30c3);
        host.setClear(1'b0);
        host.pulseClear(1);
        tick(4);
        rs(32'h3);
        wr(`PMSF_ADDR_CORR1, 32'h32);
        pv1 <= 32'h65 + ($urandom % 32'h10);
        pv2 <= $urandom % 32'h100;
        {pre1, pre2} <= 2'h3;
        tick(1);
        {pre1, pre2} <= 2'h0;
        tick(4);
        rs(32'h1107);
        rd(`PMSF_ADDR_POS1, pv1);
        rd(`PMSF_ADDR_POS2, pv2);
        host.pulseClear(1);
        tick(4);
        rs(32'h1007);
        wr(`PMSF_ADDR_CORR1, `PMSF_CORR_RST);
        pv1 <= 32'h0;
        pre1 <= 1'b1;
        tick(1);
        pre1 <= 1'b0;
        host.pulseClear(1);
        tick(4);
        rs(32'h3);
        wr(`PMSF_ADDR_JUMP2, 32'ha);
        m2 <= 32'hb;
        tick(2 * WIN + 4);
        rs(32'h2803);
        host.pulseClear(1);
        tick(4);
        rs(32'h3);
        m2 <= 32'h15;
        tick(2 * WIN + 4);
        rs(32'h3);
        wr(`PMSF_ADDR_CONTROL, 32'h1);
        tick(4);
        rs(32'h1003);
        wr(`PMSF_ADDR_CONTROL, 32'h0);
        host.pulseClear(1);
        tick(4);
        rs(32'h3);
        host.setReady(1'b0);
        wdog <= 1'b1;
        tick(1);
        wdog <= 1'b0;
        tick(6);
        rs(32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
